// ===== ramp_profile_pkg.sv
// Constants, register map and phase codes for the pulse ramp profile block.
// Assumes a 32-bit AHB-Lite bus whose low eight address bits select a register.
package ramp_profile_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_POS_AMOUNT = 8'h08;
	localparam logic [7:0] ADDR_START_SPEED = 8'h0c;
	localparam logic [7:0] ADDR_OPER_SPEED = 8'h10;
	localparam logic [7:0] ADDR_ACCEL_RATE = 8'h14;
	localparam logic [7:0] ADDR_DECEL_RATE = 8'h18;
	localparam logic [7:0] ADDR_SPEED_MAG = 8'h1c;
	localparam logic [7:0] ADDR_DECEL_POINT = 8'h20;
	localparam logic [7:0] ADDR_S_ACCEL = 8'h24;
	localparam logic [7:0] ADDR_S_DECEL = 8'h28;
	localparam logic [7:0] ADDR_STATUS = 8'h2c;
	localparam logic [7:0] ADDR_CUR_SPEED = 8'h30;
	localparam logic [7:0] ADDR_REMAIN = 8'h34;

	// ==========================================================
	// Field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_DSTOP_BIT = 1;
	localparam int CTRL_ISTOP_BIT = 2;
	localparam int MODE_SCURVE_BIT = 0;
	localparam int MODE_MANUAL_BIT = 1;

	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_SPEED = 16'h0001;
	localparam logic [15:0] RST_RATE = 16'h0001;
	localparam logic [15:0] RST_DECEL_RATE = 16'h0000;
	localparam logic [11:0] RST_SPEED_MAG = 12'h002;
	localparam logic [27:0] RST_POS_AMOUNT = 28'h0000000;
	localparam logic [23:0] RST_DECEL_POINT = 24'h000000;
	localparam logic [14:0] RST_S_RANGE = 15'h0000;
	localparam logic [1:0] RST_MODE = 2'h0;

	// ==========================================================
	// Reference clock cycles per speed step, per unit of (rate + 1)
	localparam logic [3:0] STEP_CYC_LIN = 4'h4;
	localparam logic [3:0] STEP_CYC_S = 4'h8;

	// ==========================================================
	// Ramp phases
	typedef enum logic [4:0] {
		PH_IDLE = 5'b00001,
		PH_ACCEL = 5'b00010,
		PH_CRUISE = 5'b00100,
		PH_DECEL = 5'b01000,
		PH_TAIL = 5'b10000
	} phase_t;

endpackage

// ===== pulse_ramp_profile_setup.sv
// Pulse ramp generator for one axis with its AHB-Lite profile registers.
// Assumes hclk is the reference clock and a single master with no wait states.
//
// Functional notes
// RULE1 - S-curve with accel range: accel time (top-start+2*range)*(rate+1)*4 clocks
// RULE2 - Hold a 16-bit deceleration rate setting deceleration characteristic
// RULE3 - Deceleration rate applies also with automatic decel start point
// RULE4 - Deceleration rate zero means acceleration rate is used instead
// RULE5 - Software picks manual point when decel time is long versus accel
// RULE6 - Linear mode: decel time (top-start)*(decel rate+1)*4 clocks
// RULE7 - S-curve, zero decel range: decel time (top-start)*(decel rate+1)*8 clocks
// RULE8 - S-curve with decel range: (top-start+2*range)*(decel rate+1)*4 clocks
// RULE9 - Hold 12-bit magnification; speed unit is fclk/((mag+1)*65536)
// RULE10 - Hold 24-bit decel start point; meaning follows manual/automatic select
// RULE11 - Manual: decelerate once remaining pulse count is at or below point
// RULE12 - Automatic: point is signed offset on computed point, early or late
// RULE13 - Hold 15-bit S accel range; S shaping at both band ends, linear between
// RULE14 - Zero S accel range uses half of (top-start), pure S-curve
// RULE15 - Hold 15-bit S decel range; S shaping at both band ends, linear between
// RULE16 - Zero S decel range uses half of (top-start), pure S-curve
// RULE17 - Software keeps magnification as small as the speed range allows
// RULE18 - Software sets manual linear point from speeds, decel rate and mag
// RULE19 - Software sets triangle-run point from amount less idling pulses
// RULE20 - Start speed pulse rate is value*fclk/((mag+1)*65536)
// RULE21 - Latch all profile values at start; hold them during the motion
`timescale 1ns/1ps

module pulse_ramp_profile_setup
	import ramp_profile_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Motor driver
	output logic pulse_out,
	output logic dir_out,
	output logic busy_out
);

	// ==========================================================
	// Helpers

	// Step lies in an S band: near the low end or near the high end
	function automatic logic in_band(input logic [15:0] lo_dist, input logic [15:0] hi_dist,
		input logic [15:0] range);
		in_band = (lo_dist < range) || (hi_dist <= range);
	endfunction

	// ==========================================================
	// Bus slave
	logic acc_ok;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r;
	logic hresp_r;
	logic [31:0] rd_val;
	logic wr_hit;

	assign acc_ok = hsel && htrans[1] && hready;
	assign wr_hit = wr_pend_r;

	// Software registers
	logic [1:0] mode_r;
	logic [27:0] pos_amount_r;
	logic [15:0] start_speed_value_r;
	logic [15:0] operating_speed_value_r;
	logic [15:0] accel_rate_r;
	logic [15:0] decel_rate_r;
	logic [11:0] speed_magnification_r;
	logic [23:0] decel_start_point_r;
	logic [14:0] scurve_accel_range_r;
	logic [14:0] scurve_decel_range_r;

	// Ramp state
	phase_t phase_r;
	logic [15:0] spd_r;
	logic [27:0] remain_r;
	logic [27:0] accel_pulses_r;
	logic stop_req_r;
	logic pulse_r;
	logic dir_r;
	logic busy_r;

	// Address phase capture; writes land in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= acc_ok && hwrite;
			if (acc_ok) begin
				wr_addr_r <= haddr[7:0];
			end
		end
	end

	// Read mux, unmapped reads as zero
	always_comb begin
		rd_val = 32'h00000000;
		case (haddr[7:0])
			ADDR_MODE: rd_val = {30'h0, mode_r};
			ADDR_POS_AMOUNT: rd_val = {4'h0, pos_amount_r};
			ADDR_START_SPEED: rd_val = {16'h0, start_speed_value_r};
			ADDR_OPER_SPEED: rd_val = {16'h0, operating_speed_value_r};
			ADDR_ACCEL_RATE: rd_val = {16'h0, accel_rate_r};
			ADDR_DECEL_RATE: rd_val = {16'h0, decel_rate_r};
			ADDR_SPEED_MAG: rd_val = {20'h0, speed_magnification_r};
			ADDR_DECEL_POINT: rd_val = {8'h0, decel_start_point_r};
			ADDR_S_ACCEL: rd_val = {17'h0, scurve_accel_range_r};
			ADDR_S_DECEL: rd_val = {17'h0, scurve_decel_range_r};
			ADDR_STATUS: rd_val = {25'h0, stop_req_r, busy_r, phase_r};
			ADDR_CUR_SPEED: rd_val = {16'h0, spd_r};
			ADDR_REMAIN: rd_val = {4'h0, remain_r};
			default: rd_val = 32'h00000000;
		endcase
	end

	// Read data registered at the address phase, zero wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
			if (acc_ok && !hwrite) begin
				hrdata_r <= rd_val;
			end
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;

	// Profile register writes; new values take effect at the next start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= RST_MODE;
			pos_amount_r <= RST_POS_AMOUNT;
			start_speed_value_r <= RST_SPEED;
			operating_speed_value_r <= RST_SPEED;
			accel_rate_r <= RST_RATE;
			decel_rate_r <= RST_DECEL_RATE;
			speed_magnification_r <= RST_SPEED_MAG;
			decel_start_point_r <= RST_DECEL_POINT;
			scurve_accel_range_r <= RST_S_RANGE;
			scurve_decel_range_r <= RST_S_RANGE;
		end else if (wr_hit) begin
			case (wr_addr_r)
				ADDR_MODE: mode_r <= hwdata[1:0];
				ADDR_POS_AMOUNT: pos_amount_r <= hwdata[27:0];
				ADDR_START_SPEED: start_speed_value_r <= hwdata[15:0];
				ADDR_OPER_SPEED: operating_speed_value_r <= hwdata[15:0];
				ADDR_ACCEL_RATE: accel_rate_r <= hwdata[15:0];
				ADDR_DECEL_RATE: decel_rate_r <= hwdata[15:0]; // RULE2
				ADDR_SPEED_MAG: speed_magnification_r <= hwdata[11:0]; // RULE9
				ADDR_DECEL_POINT: decel_start_point_r <= hwdata[23:0]; // RULE10
				ADDR_S_ACCEL: scurve_accel_range_r <= hwdata[14:0]; // RULE13
				ADDR_S_DECEL: scurve_decel_range_r <= hwdata[14:0]; // RULE15
				default: ;
			endcase
		end
	end

	// Command strobes from the control register
	logic cmd_start;
	logic cmd_dstop;
	logic cmd_istop;

	assign cmd_start = wr_hit && (wr_addr_r == ADDR_CTRL) && hwdata[CTRL_START_BIT];
	assign cmd_dstop = wr_hit && (wr_addr_r == ADDR_CTRL) && hwdata[CTRL_DSTOP_BIT];
	assign cmd_istop = wr_hit && (wr_addr_r == ADDR_CTRL) && hwdata[CTRL_ISTOP_BIT];

	// ==========================================================
	// Run copies of the profile
	logic [15:0] run_lo_r;
	logic [15:0] run_hi_r;
	logic [16:0] run_ar1_r;
	logic [16:0] run_dr1_r;
	logic [11:0] run_mag_r;
	logic [15:0] run_us_r;
	logic [15:0] run_ds_r;
	logic run_scurve_r;
	logic run_manual_r;
	logic [23:0] run_dsp_r;
	logic go;
	logic [15:0] half_span;

	assign go = cmd_start && (phase_r == PH_IDLE) && (pos_amount_r != 28'h0000000);
	assign half_span = 16'((operating_speed_value_r - start_speed_value_r) >> 1);

	// Latch everything at start so later writes cannot disturb the motion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_lo_r <= RST_SPEED;
			run_hi_r <= RST_SPEED;
			run_ar1_r <= 17'h00002;
			run_dr1_r <= 17'h00002;
			run_mag_r <= RST_SPEED_MAG;
			run_us_r <= 16'h0000;
			run_ds_r <= 16'h0000;
			run_scurve_r <= 1'b0;
			run_manual_r <= 1'b0;
			run_dsp_r <= RST_DECEL_POINT;
		end else if (go) begin // RULE21
			run_lo_r <= start_speed_value_r;
			run_hi_r <= operating_speed_value_r;
			run_ar1_r <= {1'b0, accel_rate_r} + 17'h00001;
			run_dr1_r <= (decel_rate_r == 16'h0000) ? {1'b0, accel_rate_r} + 17'h00001 // RULE4
				: {1'b0, decel_rate_r} + 17'h00001; // RULE3
			run_mag_r <= speed_magnification_r;
			run_us_r <= (scurve_accel_range_r == 15'h0000) ? half_span // RULE14
				: {1'b0, scurve_accel_range_r};
			run_ds_r <= (scurve_decel_range_r == 15'h0000) ? half_span // RULE16
				: {1'b0, scurve_decel_range_r};
			run_scurve_r <= mode_r[MODE_SCURVE_BIT];
			run_manual_r <= mode_r[MODE_MANUAL_BIT];
			run_dsp_r <= decel_start_point_r;
		end
	end

	// ==========================================================
	// Pulse train: speed unit is fclk/((mag+1)*65536)
	logic [11:0] pre_cnt_r;
	logic [15:0] phase_acc_r;
	logic tick;
	logic [16:0] acc_sum;
	logic pulse_fire;

	assign tick = (pre_cnt_r == run_mag_r);
	assign acc_sum = {1'b0, phase_acc_r} + {1'b0, spd_r};
	assign pulse_fire = tick && acc_sum[16] && busy_r && (remain_r != 28'h0000000) && !cmd_istop;

	// Prescaler by mag+1, then a 16-bit phase accumulator fed by the speed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt_r <= 12'h000;
			phase_acc_r <= 16'h0000;
		end else if (go || !busy_r) begin
			pre_cnt_r <= 12'h000;
			phase_acc_r <= 16'h0000;
		end else if (tick) begin // RULE9
			pre_cnt_r <= 12'h000;
			phase_acc_r <= acc_sum[15:0]; // RULE20
		end else begin
			pre_cnt_r <= pre_cnt_r + 12'h001;
		end
	end

	// ==========================================================
	// Speed stepping: interval (rate+1)*4, doubled inside the S bands
	logic [20:0] step_cnt_r;
	logic slow;
	logic [20:0] interval;
	logic step_due;
	logic ramping;

	assign ramping = (phase_r == PH_ACCEL) || (phase_r == PH_DECEL);

	always_comb begin
		slow = 1'b0;
		interval = 21'(run_ar1_r) * 21'(STEP_CYC_LIN); // RULE6
		if (phase_r == PH_ACCEL) begin
			slow = run_scurve_r && in_band(spd_r - run_lo_r, run_hi_r - spd_r, run_us_r); // RULE13
			interval = 21'(run_ar1_r) * 21'(slow ? STEP_CYC_S : STEP_CYC_LIN); // RULE1
		end else if (phase_r == PH_DECEL) begin
			slow = run_scurve_r && in_band(run_hi_r - spd_r, spd_r - run_lo_r, run_ds_r); // RULE15
			interval = 21'(run_dr1_r) * 21'(slow ? STEP_CYC_S : STEP_CYC_LIN); // RULE7 RULE8
		end
	end

	assign step_due = ramping && (step_cnt_r >= interval - 21'h000001);

	// Step timer counts reference clocks between speed steps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_cnt_r <= 21'h000000;
		end else if (!ramping || step_due) begin
			step_cnt_r <= 21'h000000;
		end else begin
			step_cnt_r <= step_cnt_r + 21'h000001;
		end
	end

	// Current speed, one unit per step
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			spd_r <= 16'h0000;
		end else if (go) begin
			spd_r <= start_speed_value_r;
		end else if (step_due && (phase_r == PH_ACCEL) && (spd_r < run_hi_r)) begin
			spd_r <= spd_r + 16'h0001;
		end else if (step_due && (phase_r == PH_DECEL) && (spd_r > run_lo_r)) begin
			spd_r <= spd_r - 16'h0001;
		end
	end

	// ==========================================================
	// Deceleration start point
	logic signed [47:0] lhs;
	logic signed [47:0] rhs;
	logic auto_hit;
	logic man_hit;
	logic dec_go;

	// Computed point scaled by the rate ratio, plus the signed offset
	assign lhs = $signed(48'(remain_r) * 48'(run_ar1_r));
	assign rhs = $signed(48'(accel_pulses_r) * 48'(run_dr1_r))
		+ $signed({{24{run_dsp_r[23]}}, run_dsp_r}) * $signed(48'(run_ar1_r));
	assign auto_hit = (lhs <= rhs); // RULE12
	assign man_hit = ({4'h0, run_dsp_r} >= remain_r); // RULE11
	assign dec_go = stop_req_r || (run_manual_r ? man_hit : auto_hit); // RULE10

	// Pulses spent while accelerating feed the automatic point
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			accel_pulses_r <= 28'h0000000;
		end else if (go) begin
			accel_pulses_r <= 28'h0000000;
		end else if (pulse_fire && (phase_r == PH_ACCEL)) begin
			accel_pulses_r <= accel_pulses_r + 28'h0000001;
		end
	end

	// Remaining pulse count and direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			remain_r <= 28'h0000000;
			dir_r <= 1'b0;
		end else if (go) begin
			dir_r <= pos_amount_r[27];
			remain_r <= pos_amount_r[27] ? 28'(~pos_amount_r + 28'h0000001) : pos_amount_r;
		end else if (pulse_fire) begin
			remain_r <= remain_r - 28'h0000001;
		end
	end

	// Deceleration stop request held for the motion
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_req_r <= 1'b0;
		end else if (go || (phase_r == PH_IDLE)) begin
			stop_req_r <= 1'b0;
		end else if (cmd_dstop) begin
			stop_req_r <= 1'b1;
		end
	end

	// ==========================================================
	// Phase sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_r <= PH_IDLE;
		end else if (cmd_istop || (pulse_fire && (remain_r == 28'h0000001))) begin
			phase_r <= PH_IDLE;
		end else begin
			case (phase_r)
				PH_IDLE: begin
					if (go) begin
						phase_r <= PH_ACCEL;
					end
				end
				PH_ACCEL: begin
					if (dec_go) begin
						phase_r <= PH_DECEL;
					end else if (spd_r >= run_hi_r) begin
						phase_r <= PH_CRUISE;
					end
				end
				PH_CRUISE: begin
					if (dec_go) begin
						phase_r <= PH_DECEL;
					end
				end
				PH_DECEL: begin
					if (spd_r <= run_lo_r) begin
						phase_r <= stop_req_r ? PH_IDLE : PH_TAIL;
					end
				end
				PH_TAIL: begin
					if (stop_req_r) begin
						phase_r <= PH_IDLE;
					end
				end
				default: phase_r <= PH_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Driver outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			pulse_r <= pulse_fire;
			// Falls one cycle after the last pulse, so that pulse lies inside the frame
			busy_r <= go || (busy_r && !cmd_istop && !(phase_r == PH_IDLE && !go));
		end
	end

	assign pulse_out = pulse_r;
	assign dir_out = dir_r;
	assign busy_out = busy_r;

endmodule

// ===== motor_drv_model.sv
// Motor driver model: counts step pulses of a motion and times the last gap.
// Assumes pulse_out is a one-cycle pulse and busy_out frames each motion.
`timescale 1ns/1ps

module motor_drv_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pulse link
	input wire logic pulse_out,
	input wire logic busy_out,
	// Observations
	output int pulses,
	output int gap
);
	int since;
	logic busy_q;

	// ==========================================================
	// Pulse count per motion, cycles between the last two pulses
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulses <= 0;
			gap <= 0;
			since <= 0;
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_out;
			since <= since + 1;
			if (busy_out && !busy_q) begin
				pulses <= 0;
				since <= 0;
			end else if (pulse_out) begin
				pulses <= pulses + 1;
				gap <= since + 1;
				since <= 0;
			end
		end
	end
endmodule

// ===== ramp_profile_monitor.sv
// Checker on the ports of the ramp profile block.
// Assumes it is bound into pulse_ramp_profile_setup.
`timescale 1ns/1ps

module ramp_profile_monitor
	import ramp_profile_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Motor side
	input wire logic pulse_out,
	input wire logic dir_out,
	input wire logic busy_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic ctl_r, go_r, halt_r, dst_r;
	logic [31:0] hi_r;
	wire tk = hsel && htrans[1] && hready;

	// Bits that must read zero at an address
	function automatic logic [31:0] hmask(input logic [7:0] a);
		case (a)
			ADDR_DECEL_RATE: hmask = 32'hffff0000;
			ADDR_SPEED_MAG: hmask = 32'hfffff000;
			ADDR_DECEL_POINT: hmask = 32'hff000000;
			ADDR_S_ACCEL, ADDR_S_DECEL: hmask = 32'hffff8000;
			ADDR_CTRL: hmask = 32'hffffffff;
			default: hmask = (a > 8'h34) ? 32'hffffffff : 32'h0;
		endcase
	endfunction

	// ==========================================================
	// Control write data phases and read masks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_r <= 1'b0;
			go_r <= 1'b0;
			halt_r <= 1'b0;
			dst_r <= 1'b0;
			hi_r <= 32'h0;
		end else begin
			// Decel stop pending until the frame closes
			if (ctl_r && hwdata[1]) begin
				dst_r <= 1'b1;
			end else if (!busy_out) begin
				dst_r <= 1'b0;
			end
			ctl_r <= tk && hwrite && haddr[7:0] == ADDR_CTRL;
			go_r <= ctl_r && hwdata[0];
			halt_r <= ctl_r && hwdata[2];
			if (tk && !hwrite) begin
				hi_r <= hmask(haddr[7:0]);
			end
		end
	end

	// ==========================================================
	// Assertions
	sequence s_rd;
		tk && !hwrite;
	endsequence
	a_field_width: assert property (s_rd |=> (hrdata & hi_r) == 32'h0)
		else $error("read data above field width");
	a_pulse_spacing: assert property (pulse_out |=> !pulse_out [*2])
		else $error("pulses closer than three cycles");
	a_pulse_busy: assert property (pulse_out |-> busy_out)
		else $error("pulse outside a motion");
	a_dir_held: assert property (busy_out && $past(busy_out) |-> $stable(dir_out))
		else $error("direction changed in a motion");
	a_busy_cause: assert property ($rose(busy_out) |-> go_r || $past(go_r))
		else $error("motion began without a start write");
	a_busy_end: assert property ($fell(busy_out) |-> $past(pulse_out) || halt_r || $past(halt_r)
		|| dst_r)
		else $error("motion ended without a last pulse");
	a_ready_high: assert property (hreadyout)
		else $error("ready dropped");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
endmodule

bind pulse_ramp_profile_setup ramp_profile_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.pulse_out(pulse_out), .dir_out(dir_out), .busy_out(busy_out));

// ===== test_pulse_ramp_profile_setup.sv
// Bench for the ramp profile block: registers, ramp times, pulse rates.
// Assumes the driver model and the bound checker are compiled first.
`timescale 1ns/1ps

module test_pulse_ramp_profile_setup
	import ramp_profile_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, pulse_out, dir_out, busy_out;
	int pulses, gap, cyc, err_count, checks_done;
	localparam logic [7:0] RA [10] = '{ADDR_MODE, ADDR_POS_AMOUNT, ADDR_START_SPEED,
		ADDR_OPER_SPEED, ADDR_ACCEL_RATE, ADDR_DECEL_RATE, ADDR_SPEED_MAG, ADDR_DECEL_POINT,
		ADDR_S_ACCEL, ADDR_S_DECEL};
	localparam logic [31:0] RV [10] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h1, 32'h0, 32'h2,
		32'h0, 32'h0, 32'h0};
	localparam logic [31:0] RM [10] = '{32'h3, 32'hfffffff, 32'hffff, 32'hffff, 32'hffff,
		32'hffff, 32'hfff, 32'hffffff, 32'h7fff, 32'h7fff};

	pulse_ramp_profile_setup DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pulse_out(pulse_out),
		.dir_out(dir_out), .busy_out(busy_out));
	motor_drv_model u_drv (.hclk(hclk), .hresetn(hresetn), .pulse_out(pulse_out),
		.busy_out(busy_out), .pulses(pulses), .gap(gap));

	// ==========================================================
	// Clock, cycle count and hang limit
	always #10 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			complete_run();
		end
	end

	// ==========================================================
	// Verdict
	task complete_run();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compare exact and near values
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task near(input string n, input int e, input int g, input int tol);
		checks_done++;
		if (g < e - tol || g > e + tol) begin
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
			err_count++;
		end
	endtask

	// ==========================================================
	// Single AHB-Lite transfers
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	// Profile set-up: start speed 16384 (exact four ticks a pulse), top 16424, accel rate 1
	task cfg(input logic [31:0] md, am, dr, mg, pt, us, ds);
		wr(ADDR_START_SPEED, 32'h4000);
		wr(ADDR_OPER_SPEED, 32'h4028);
		wr(ADDR_ACCEL_RATE, 32'h1);
		wr(ADDR_MODE, md);
		wr(ADDR_POS_AMOUNT, am);
		wr(ADDR_DECEL_RATE, dr);
		wr(ADDR_SPEED_MAG, mg);
		wr(ADDR_DECEL_POINT, pt);
		wr(ADDR_S_ACCEL, us);
		wr(ADDR_S_DECEL, ds);
	endtask

	// Start, upset the decel rate, time accel and decel phases by polling
	task go(output int ta, output int td, output logic [31:0] rem);
		int t0, tc, tdc, tt;
		logic [31:0] s;
		wr(ADDR_CTRL, 32'h1);
		t0 = cyc;
		tc = 0;
		tdc = 0;
		tt = 0;
		rem = 32'hffffffff;
		wr(ADDR_DECEL_RATE, 32'h7);
		do begin
			rd(ADDR_STATUS, s);
			if (s[2] && tc == 0) tc = cyc;
			if (s[3] && tdc == 0) begin
				tdc = cyc;
				rd(ADDR_REMAIN, rem);
			end
			if (s[4] && tt == 0) tt = cyc;
		end while (s[5] === 1'b1);
		ta = tc - t0;
		td = (tt == 0) ? -1 : tt - tdc;
	endtask

	// ==========================================================
	// Scenarios
	task t_regs();
		logic [31:0] q;
		for (int i = 0; i < 10; i++) begin
			rd(RA[i], q);
			chk("reset value", RV[i], q);
			wr(RA[i], 32'hffffffff);
			rd(RA[i], q);
			chk("field width", RM[i], q);
		end
		rd(ADDR_CTRL, q);
		chk("control reads zero", 32'h0, q);
		wr(ADDR_STATUS, 32'hffffffff);
		rd(ADDR_STATUS, q);
		chk("status idle", 32'h1, q);
		wr(8'h3c, 32'hffffffff);
		rd(8'h3c, q);
		chk("unmapped", 32'h0, q);
	endtask

	task t_linear();
		int ta, td;
		logic [31:0] rem;
		cfg(32'h2, 32'h12c, 32'h3, 32'h2, 32'h64, 32'h0, 32'h0);
		go(ta, td, rem);
		near("accel time", 320, ta, 8);
		near("decel time", 640, td, 8);
		chk("remaining at decel", 32'h1, {31'h0, rem <= 32'h64});
		chk("pulse count", 32'h12c, pulses);
		chk("direction", 32'h0, {31'h0, dir_out});
		near("start speed gap", 12, gap, 1);
	endtask

	task t_decel_zero();
		int ta, td;
		logic [31:0] rem;
		cfg(32'h2, 32'hffffed4, 32'h0, 32'h2, 32'h64, 32'h0, 32'h0);
		go(ta, td, rem);
		near("decel time", 320, td, 8);
		chk("pulse count", 32'h12c, pulses);
		chk("direction", 32'h1, {31'h0, dir_out});
	endtask

	task t_scurve();
		int ta, td;
		logic [31:0] rem;
		cfg(32'h3, 32'h12c, 32'h1, 32'h2, 32'h64, 32'h0, 32'h0);
		go(ta, td, rem);
		near("pure s accel", 640, ta, 8);
		near("pure s decel", 640, td, 8);
		cfg(32'h3, 32'h12c, 32'h1, 32'h5, 32'h64, 32'h5, 32'h5);
		go(ta, td, rem);
		near("banded accel", 400, ta, 8);
		near("banded decel", 400, td, 8);
		near("start speed gap", 24, gap, 1);
	endtask

	task t_auto();
		int ta, td;
		logic [31:0] rem;
		cfg(32'h0, 32'h12c, 32'h3, 32'h2, 32'h64, 32'h0, 32'h0);
		go(ta, td, rem);
		near("auto decel time", 640, td, 8);
		near("early offset", 153, rem, 8);
		near("fed at start speed", 12, gap, 1);
		cfg(32'h0, 32'h12c, 32'h3, 32'h2, 32'hffffec, 32'h0, 32'h0);
		go(ta, td, rem);
		chk("late offset stops fast", 32'h1, {31'h0, td == -1 && rem != 32'hffffffff});
	endtask

	task t_point_zero();
		int ta, td;
		logic [31:0] rem;
		cfg(32'h2, 32'h12c, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0);
		go(ta, td, rem);
		chk("no decel", 32'hffffffff, rem);
		chk("pulse count", 32'h12c, pulses);
		cfg(32'h2, 32'h28, 32'h1, 32'h2, 32'h14, 32'h0, 32'h0);
		go(ta, td, rem);
		chk("triangle count", 32'h28, pulses);
		chk("triangle decel", 32'h1, {31'h0, rem <= 32'h14});
	endtask

	// Immediate stop, then decel stop, on the triangle profile
	task t_stop();
		logic [31:0] q;
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_CTRL, 32'h4);
		rd(ADDR_STATUS, q);
		chk("immediate stop", 32'h1, q);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_CTRL, 32'h2);
		do rd(ADDR_STATUS, q); while (q[5] === 1'b1);
		chk("decel stop idle", 32'h1, q);
		chk("decel stop early", 32'h1, {31'h0, pulses < 32'h28});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_linear();
		t_decel_zero();
		t_scurve();
		t_auto();
		t_point_zero();
		t_stop();
		complete_run();
	end
endmodule
